// [verilog/ctm_map.svh]
// Register offsets, field positions, reset values and divider ratios of the capture timer.
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH

`define CTM_IDX_MODE 8'hBC
`define CTM_IDX_CAP_FALL 8'hBD
`define CTM_IDX_CAP_RISE 8'hBE
`define CTM_ADDR_W 10
`define CTM_RST_MODE 8'h00
`define CTM_RST_CAP 8'h00
`define CTM_BIT_OVF_HI 7
`define CTM_BIT_OVF_LO 6
`define CTM_BIT_IRQ_EN 5
`define CTM_BIT_EDGE_SEL 4
`define CTM_BIT_CLR_HI 3
`define CTM_BIT_CLR_LO 2
`define CTM_BIT_CKS_HI 1
`define CTM_BIT_CKS_LO 0
`define CTM_CKS_DIV64 2'h0
`define CTM_CKS_DIV32 2'h1
`define CTM_CKS_DIV4 2'h2
`define CTM_CKS_DIV2 2'h3
`define CTM_MASK_DIV64 7'h3F
`define CTM_MASK_DIV32 7'h1F
`define CTM_MASK_DIV4 7'h03
`define CTM_MASK_DIV2 7'h01
`define CTM_CNT_MAX 8'hFF

`endif

// [verilog/ctm_pkg.sv]
// Types shared by the capture timer modules.
package ctm_pkg;

    typedef enum logic [1:0] {
        CTM_CLR_NONE,
        CTM_CLR_FALL,
        CTM_CLR_RISE,
        CTM_CLR_BOTH
    } ctm_clr_e;

    typedef struct packed {
        logic [6:0] div;
        logic tick;
    } ctm_pre_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic cap_prev;
        logic ovf_hi;
        logic ovf_lo;
        logic irq_en;
        logic edge_sel;
        ctm_clr_e clr_sel;
        logic [1:0] cks;
        logic arm_hi;
        logic arm_lo;
        logic [7:0] cap_fall;
        logic [7:0] cap_rise;
        logic ack;
        logic [7:0] rdata;
        logic cap_irq;
    } ctm_state_s;

endpackage

// [verilog/ctm_prescale.sv]
// Prescaler that turns the system clock into count ticks for the capture timer.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_map.svh"

module ctm_prescale
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    output logic tick
);

    ctm_pre_s st_ff;
    ctm_pre_s nxt_st;
    logic [6:0] mask;

    always_comb begin
        case (sel)
            `CTM_CKS_DIV64: mask = `CTM_MASK_DIV64;
            `CTM_CKS_DIV32: mask = `CTM_MASK_DIV32;
            `CTM_CKS_DIV4: mask = `CTM_MASK_DIV4;
            default: mask = `CTM_MASK_DIV2;
        endcase
        nxt_st.div = st_ff.div + 7'h01;
        // A tick when all bits under the mask are set gives an exact ratio per setting.
        nxt_st.tick = ((st_ff.div & mask) == mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule
`default_nettype wire

// [verilog/ctm_timer.sv]
// Eight-bit input capture timer with mode register and two capture registers on Avalon-MM.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_map.svh"

// Overview of operation
// - Counter wrap FF to 00 sets overflow flag.
// - Flag clears by zero write after reading one.
// - Writing one to flags changes nothing.
// - Capture registers read-only, reset zero.
module ctm_timer
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CTM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_in,
    output logic overflow_irq,
    output logic capture_irq,
    output logic [7:0] capture_timer_count
);

    ctm_state_s st_ff;
    ctm_state_s nxt_st;
    logic tick;
    logic req;
    logic done;
    logic fall_edge;
    logic rise_edge;
    logic clr_now;
    logic wrap;
    logic [7:0] mode_byte;

    // The register index sits in address bits above the byte lane.
    function automatic logic hit(input logic [`CTM_ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr[`CTM_ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    ctm_prescale u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .sel(st_ff.cks),
        .tick(tick)
    );

    assign req = avs_read | avs_write;
    assign done = req & st_ff.ack;
    assign fall_edge = st_ff.cap_prev & ~capture_in;
    assign rise_edge = ~st_ff.cap_prev & capture_in;
    assign mode_byte = {st_ff.ovf_hi, st_ff.ovf_lo, st_ff.irq_en, st_ff.edge_sel,
                        st_ff.clr_sel, st_ff.cks};

    always_comb begin
        case (st_ff.clr_sel)
            CTM_CLR_FALL: clr_now = fall_edge;
            CTM_CLR_RISE: clr_now = rise_edge;
            CTM_CLR_BOTH: clr_now = fall_edge | rise_edge;
            default: clr_now = 1'b0;
        endcase
    end

    // A clear from the capture edge takes precedence, so a clear at count FF is not a wrap.
    assign wrap = tick & ~clr_now & (st_ff.cnt == `CTM_CNT_MAX);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.cap_prev = capture_in;
        if (clr_now) begin
            nxt_st.cnt = 8'h00;
        end else if (tick) begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
        if (fall_edge) begin
            nxt_st.cap_fall = st_ff.cnt;
        end
        if (rise_edge) begin
            nxt_st.cap_rise = st_ff.cnt;
        end
        nxt_st.cap_irq = st_ff.edge_sel ? rise_edge : fall_edge;
        // One wait state: the first edge of a request loads read data, the second completes.
        nxt_st.ack = req & ~st_ff.ack;
        if (req && !st_ff.ack) begin
            if (avs_read && hit(avs_address, `CTM_IDX_MODE)) begin
                nxt_st.rdata = mode_byte;
            end else if (avs_read && hit(avs_address, `CTM_IDX_CAP_FALL)) begin
                nxt_st.rdata = st_ff.cap_fall;
            end else if (avs_read && hit(avs_address, `CTM_IDX_CAP_RISE)) begin
                nxt_st.rdata = st_ff.cap_rise;
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
        if (done && avs_read && hit(avs_address, `CTM_IDX_MODE)) begin
            if (st_ff.rdata[`CTM_BIT_OVF_HI]) begin
                nxt_st.arm_hi = 1'b1;
            end
            if (st_ff.rdata[`CTM_BIT_OVF_LO]) begin
                nxt_st.arm_lo = 1'b1;
            end
        end
        // Capture registers have no write path at all.
        if (done && avs_write && hit(avs_address, `CTM_IDX_MODE)) begin
            nxt_st.irq_en = avs_writedata[`CTM_BIT_IRQ_EN];
            nxt_st.edge_sel = avs_writedata[`CTM_BIT_EDGE_SEL];
            nxt_st.clr_sel = ctm_clr_e'(avs_writedata[`CTM_BIT_CLR_HI:`CTM_BIT_CLR_LO]);
            nxt_st.cks = avs_writedata[`CTM_BIT_CKS_HI:`CTM_BIT_CKS_LO];
            // A one written to a flag is dropped; a zero clears only when armed.
            if (!avs_writedata[`CTM_BIT_OVF_HI] && st_ff.arm_hi) begin
                nxt_st.ovf_hi = 1'b0;
                nxt_st.arm_hi = 1'b0;
            end
            if (!avs_writedata[`CTM_BIT_OVF_LO] && st_ff.arm_lo) begin
                nxt_st.ovf_lo = 1'b0;
                nxt_st.arm_lo = 1'b0;
            end
        end
        // Set comes last so an overflow in the clearing cycle is kept.
        if (wrap) begin
            nxt_st.ovf_hi = 1'b1;
        end
        // The low flag also records that the wrap came while the capture input was low.
        if (wrap && !st_ff.cap_prev) begin
            nxt_st.ovf_lo = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest = req & ~st_ff.ack;
    assign avs_readdata = {24'h000000, st_ff.rdata};
    assign overflow_irq = st_ff.irq_en & (st_ff.ovf_hi | st_ff.ovf_lo);
    assign capture_irq = st_ff.cap_irq;
    assign capture_timer_count = st_ff.cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_wrap_sets_flag: assert property (
        (tick && !clr_now && st_ff.cnt == `CTM_CNT_MAX) |=> (st_ff.cnt == 8'h00)
            && st_ff.ovf_hi)
        else $error("Counter wrap did not set the high overflow flag.");

    a_clear_after_read: assert property (
        $fell(st_ff.ovf_hi) |-> $past(st_ff.arm_hi) && $past(done && avs_write))
        else $error("High overflow flag cleared without a prior read of one.");

    a_flag_only_by_wrap: assert property (
        $rose(st_ff.ovf_lo) |-> $past(wrap) && !$past(st_ff.cap_prev))
        else $error("Low overflow flag set without a counter wrap.");

    a_capture_readonly: assert property (
        $changed(st_ff.cap_rise) |-> $past(rise_edge) && (st_ff.cap_rise == $past(st_ff.cnt)))
        else $error("Rising capture value changed without a rising edge.");

    a_irq_gating: assert property (
        (!st_ff.irq_en |-> !overflow_irq)
            and ((st_ff.irq_en && $rose(st_ff.ovf_hi)) |-> overflow_irq))
        else $error("Overflow interrupt does not follow enable and flag.");

    a_bus_one_wait: assert property (
        ($rose(req) && !st_ff.ack) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus access did not finish after one wait state.");

    a_bus_idle_nowait: assert property (
        !req |-> !avs_waitrequest)
        else $error("Waitrequest high without a bus request.");

    a_lo_clear_read: assert property (
        $fell(st_ff.ovf_lo) |-> $past(st_ff.arm_lo) && $past(done && avs_write))
        else $error("Low overflow flag cleared without a prior read of one.");

    a_arm_needs_read: assert property (
        $rose(st_ff.arm_hi) |-> $past(done && avs_read) && $past(st_ff.rdata[`CTM_BIT_OVF_HI]))
        else $error("High flag armed for clearing without a read of one.");

    a_one_write_kept: assert property (
        (done && avs_write && avs_writedata[`CTM_BIT_OVF_HI] && st_ff.ovf_hi) |=> st_ff.ovf_hi)
        else $error("Writing one to the high overflow flag changed it.");

    a_hi_set_by_wrap: assert property (
        $rose(st_ff.ovf_hi) |-> $past(wrap))
        else $error("High overflow flag set without a counter wrap.");

    a_fall_capture: assert property (
        $changed(st_ff.cap_fall) |-> $past(fall_edge) && (st_ff.cap_fall == $past(st_ff.cnt)))
        else $error("Falling capture value changed without a falling edge.");

    a_count_step: assert property (
        $changed(st_ff.cnt) |-> $past(tick) || $past(clr_now))
        else $error("Counter moved without a tick or a clear.");

    a_count_inc: assert property (
        (tick && !clr_now) |=> (st_ff.cnt == $past(st_ff.cnt) + 8'h01))
        else $error("Counter did not advance by one on a tick.");

    a_clear_zeroes: assert property (
        clr_now |=> (st_ff.cnt == 8'h00))
        else $error("Selected capture edge did not clear the counter.");

    a_capture_pulse: assert property (
        (st_ff.edge_sel ? rise_edge : fall_edge) |=> capture_irq)
        else $error("Selected capture edge gave no capture pulse.");

    c_overflow_hi: cover property (wrap && st_ff.cap_prev);
    c_flag_cleared: cover property ($fell(st_ff.ovf_lo));
    c_clear_on_edge: cover property (clr_now && st_ff.cnt != 8'h00);
    c_set_wins: cover property (wrap && done && avs_write && st_ff.arm_hi);

endmodule
`default_nettype wire

// [tb/test_ctm_timer.sv]
// Self-checking bench for the capture timer mode flags, capture registers and overflow interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_map.svh"

module test_ctm_timer;
    localparam logic [9:0] A_MODE = {`CTM_IDX_MODE, 2'h0};
    localparam logic [9:0] A_FALL = {`CTM_IDX_CAP_FALL, 2'h0};
    localparam logic [9:0] A_RISE = {`CTM_IDX_CAP_RISE, 2'h0};
    localparam logic [9:0] A_NONE = 10'h3FC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`CTM_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic capture_in = 1'b1;
    logic overflow_irq;
    logic capture_irq;
    logic [7:0] capture_timer_count;
    logic [31:0] lfsr = 32'h00016BBF;
    logic [9:0] ro_addr;
    int err_count = 0;
    int total_checks = 0;
    int mode_m = 0;
    int arm_m = 0;

    ctm_timer i_ctm_timer (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .capture_in(capture_in), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
        .capture_timer_count(capture_timer_count));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // The request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // A zero write clears a flag only once a read has shown it set; a one never sets it.
    task automatic wmode(input logic [7:0] d);
        wr(A_MODE, {24'h0, d});
        mode_m = (mode_m & 8'hC0 & ~(arm_m & ~int'(d))) | (d & 8'h3F);
        arm_m = arm_m & d;
    endtask

    task automatic rmode();
        rd(A_MODE, mode_m, "mode");
        arm_m = arm_m | (mode_m & 8'hC0);
    endtask

    task automatic irq_chk();
        chk("overflow_irq", {31'h0, mode_m[5] && (mode_m & 8'hC0) != 0}, {31'h0, overflow_irq});
    endtask

    task automatic wait_wrap();
        int n;
        n = 0;
        while (capture_timer_count !== 8'hFF && n < 2000) begin
            @(posedge clk);
            n++;
        end
        while (capture_timer_count === 8'hFF && n < 2000) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk("wrap_wait", 32'h0, {31'h0, n >= 2000});
        mode_m = mode_m | 8'h80 | (capture_in ? 8'h00 : 8'h40);
    endtask

    // Any 64-cycle window holds exactly 64 / ratio ticks, whatever the prescaler phase.
    task automatic rate_chk(input logic [1:0] sel, input int ticks);
        logic [7:0] c;
        wmode({6'h0, sel});
        repeat (8) @(posedge clk);
        c = capture_timer_count;
        repeat (64) @(posedge clk);
        chk("count_rate", (int'(c) + ticks) % 256, {24'h0, capture_timer_count});
    endtask

    // The capture register takes the count of the edge that sees the new level.
    task automatic cap_edge(input logic lvl);
        logic [7:0] c;
        int clr;
        clr = (mode_m >> 2) & 3;
        @(posedge clk);
        capture_in <= lvl;
        @(posedge clk);
        c = capture_timer_count;
        chk("capture_irq_early", 32'h0, {31'h0, capture_irq});
        @(posedge clk);
        chk("capture_irq", {31'h0, lvl == mode_m[4]}, {31'h0, capture_irq});
        if (clr == 3 || clr == (lvl ? 2 : 1)) begin
            chk("count_clear", 32'h0, {24'h0, capture_timer_count});
        end
        rd(lvl ? A_RISE : A_FALL, {24'h0, c}, "capture_value");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rmode();
        for (int i = 0; i < 3; i++) begin
            ro_addr = (i == 0) ? A_FALL : (i == 1) ? A_RISE : A_NONE;
            rd(ro_addr, 32'h0, "ro_reset");
            wr(ro_addr, next_rand());
            rd(ro_addr, 32'h0, "ro_write");
        end
        wmode(8'h23);
        wait_wrap();
        irq_chk();
        wmode(8'h23);
        rmode();
        wmode(8'hE3);
        rmode();
        wmode(8'h23);
        rmode();
        irq_chk();
        capture_in <= 1'b0;
        wmode(8'h03 | 8'(next_rand() & 32'h10));
        wait_wrap();
        rmode();
        irq_chk();
        wmode(8'h03);
        rmode();
        for (int i = 0; i < 4; i++) begin
            rate_chk(2'(i), (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 16 : 32);
        end
        for (int i = 0; i < 3; i++) begin
            wmode((i == 0) ? 8'h07 : (i == 1) ? 8'h1B : 8'h0F);
            cap_edge(1'b1);
            cap_edge(1'b0);
        end
        finish_test();
    end
endmodule

`default_nettype wire
